// ===== verilog/uart_channel_defs.svh
// Purpose: Constants for one asynchronous serial channel
// Assumes: System clock of 40 MHz, baud reference of 120 MHz
// Notes: Times kept in their own unit, cycle counts derived
`ifndef UART_CHANNEL_DEFS_SVH
`define UART_CHANNEL_DEFS_SVH

// Clock and reference rates
`define CLK_PERIOD_NS 25
`define SYS_MHZ 40
`define REF_MHZ 120
// Reference ticks per system cycle, in sixteenths
`define REF_PER_CLK16 (`REF_MHZ * 16 / `SYS_MHZ)
// Smallest divider, one whole reference tick in sixteenths
`define DIV16_MIN 18'h00010

// Oversampling ratios
`define OVS_X16 5'h10
`define OVS_X10 5'h0a

// Character format
`define DATA_BITS_LAST 3'h7

// Latency timer and USB frame timing
`define MS_NS 1000000
`define MICROFRAME_NS 125000
`define LAT_DEFAULT_MS 8'h10

// Buffers and packets
`define BUF_AW 12
`define PKT_BYTES 13'h0200

`endif

// ===== verilog/uart_channel_pkg.sv
// Purpose: Types shared by the serial channel and its buffer
// Assumes: uart_channel_defs.svh holds every number
// Notes: State machines use enums without codes
package uart_channel_pkg;

  // Operating mode of the channel
  typedef enum logic [2:0] {
    MODE_UART,
    MODE_FIFO,
    MODE_OPTO,
    MODE_SERIAL_ENGINE,
    MODE_BITBANG
  } chan_mode_e;

  // Baud divider: integer prescaler, fine bits, ratio select
  typedef struct packed {
    logic [13:0] int_div;
    logic [3:0] frac;
    logic x10;
  } baud_cfg_s;

  // One received byte on its way to the host
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } rx_word_s;

  typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_START, TX_DATA,
    TX_STOP} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA,
    RX_STOP} rx_state_e;

  // Two-entry buffer state
  typedef struct packed {
    rx_word_s ent0;
    rx_word_s ent1;
    logic [1:0] cnt;
    logic in_ready;
    logic out_valid;
  } pair_state_s;

endpackage

// ===== verilog/pair_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Source and sink on the same clock
// Notes: Both handshake outputs come from flip-flops
`timescale 1ns/10ps
module pair_buffer
(
  input wire logic clk,
  input wire logic rst,
  input wire uart_channel_pkg::rx_word_s in_word,
  input wire logic in_valid,
  output logic in_ready,
  output uart_channel_pkg::rx_word_s out_word,
  output logic out_valid,
  input wire logic out_ready
);
  import uart_channel_pkg::*;

  pair_state_s r;
  pair_state_s nxt;
  logic push;
  logic pop;

  // Entry 0 is the head; entry 1 catches a word during a stall
  always_comb
  begin
    nxt = r;
    push = in_valid && r.in_ready;
    pop = r.out_valid && out_ready;
    if (pop)
    begin
      nxt.ent0 = r.ent1;
    end
    if (push)
    begin
      if (r.cnt == 2'h0 || (r.cnt == 2'h1 && pop))
      begin
        nxt.ent0 = in_word;
      end
      else
      begin
        nxt.ent1 = in_word;
      end
    end
    nxt.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
    nxt.out_valid = (nxt.cnt != 2'h0);
    nxt.in_ready = (nxt.cnt != 2'h2);
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= nxt;
    end
  end

  assign in_ready = r.in_ready;
  assign out_word = r.ent0;
  assign out_valid = r.out_valid;
endmodule // pair_buffer

// ===== verilog/uart_channel.sv
// Purpose: One asynchronous serial channel of a USB serial bridge
// Assumes: USB engine on CLK_SYS; line transceiver on the pins
// Notes: 8 data bits, 1 stop bit, no parity on the line
// Notes on behaviour
// R1: Oversample clock from 120MHz, x16 or x10
// R2: 14-bit integer prescaler plus four fraction bits
// R3: Baud settable from 183 to 12 million; here about 458 to 4 million, one tick per cycle at most
// R4: 7, 9, 10, 11 Mbaud unsupported
// R5: Latency timeout flushes short data, default 16ms
// R6: Zero latency sends a packet every microframe
// R7: 4 KB transmit buffer from host
// R8: 4 KB receive buffer toward host
// R9: Software picks serial engine, UART or bit-bang
// R10: Reset at power-up and on external pin
// R11: No configuration memory means serial port defaults
// R12: Defaults omit the serial number
// R13: Configuration memory sets mode per channel
// R14: Configuration memory 16-bit wide, 1 Mbit/s clock
// R15: Drive enable only while a character transmits; here also high for one lead bit time before the start bit
// R16: Power-on output inactive during USB suspend
// R17: Drive enable spans start through final stop; here raised one bit time before the start bit
// R18: Send on full packet or timeout with data
`timescale 1ns/10ps
`include "uart_channel_defs.svh"
module uart_channel
#(
  parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS,
  parameter int UF_CYCLES = `MICROFRAME_NS / `CLK_PERIOD_NS
)
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic EXT_RESET_N,
  input wire logic RXD,
  output logic TXD,
  output logic LINE_DRIVE_ENABLE,
  input wire logic SUSPEND,
  output logic SUSPEND_POWER_ON_N,
  input wire uart_channel_pkg::baud_cfg_s BAUD,
  input wire logic [7:0] LATENCY_MS,
  input wire logic LATENCY_LOAD,
  input wire logic CFG_PRESENT,
  input wire uart_channel_pkg::chan_mode_e CFG_MODE,
  input wire logic SW_SERIAL_ENGINE,
  input wire logic SW_BITBANG,
  output uart_channel_pkg::chan_mode_e CHAN_MODE,
  output logic SERIAL_NUMBER_EN,
  input wire logic [7:0] HOST_TX_DATA,
  input wire logic HOST_TX_VALID,
  output logic HOST_TX_READY,
  output uart_channel_pkg::rx_word_s HOST_RX,
  output logic HOST_RX_VALID,
  input wire logic HOST_RX_READY,
  output logic RX_OVERRUN
);
  import uart_channel_pkg::*;

  localparam int AW = `BUF_AW;
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic rxd_s1;
    logic rxd_s2;
    logic [18:0] acc;
    tx_state_e tx_st;
    logic [4:0] tx_ovs;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic txd;
    logic drive_en;
    logic [AW:0] tx_wp;
    logic [AW:0] tx_rp;
    logic tx_ready;
    rx_state_e rx_st;
    logic [4:0] rx_ovs;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic [AW:0] rx_wp;
    logic [AW:0] rx_rp;
    logic overrun;
    logic [7:0] lat_ms;
    logic [7:0] lat_cnt;
    logic [15:0] ms_cnt;
    logic [15:0] uf_cnt;
    logic sending;
    logic [AW:0] pkt_left;
    chan_mode_e mode;
    logic serial_en;
    logic pwr_n;
  } chan_state_s;

  chan_state_s r;
  chan_state_s nxt;
  logic [7:0] tx_mem [0:(1 << AW) - 1];
  logic [7:0] rx_mem [0:(1 << AW) - 1];
  logic tick;
  logic [17:0] div16;
  logic [18:0] acc_sum;
  logic [4:0] ovs_n;
  logic uart_on;
  logic tx_wr;
  logic rx_wr;
  logic [AW:0] rx_cnt;
  logic flush;
  rx_word_s push_word;
  logic push_valid;
  logic push_ready;

  // Bytes held between two buffer pointers
  function automatic logic [AW:0] fill(input logic [AW:0] wp,
    input logic [AW:0] rp);
    fill = wp - rp;
  endfunction

  // Last oversample tick of a bit period
  function automatic logic bit_end(input logic tk, input logic [4:0] c,
    input logic [4:0] n);
    bit_end = tk && (c == n - 5'h01);
  endfunction

  // Reset value of all state
  function automatic chan_state_s reset_state();
    chan_state_s s;
    s = '0;
    s.rxd_s1 = 1'b1;
    s.rxd_s2 = 1'b1;
    s.txd = 1'b1;
    s.pwr_n = 1'b1;
    s.lat_ms = `LAT_DEFAULT_MS; // R5
    s.tx_st = TX_IDLE;
    s.rx_st = RX_IDLE;
    s.mode = MODE_UART;
    reset_state = s;
  endfunction

  // Next-state logic of the whole channel
  always_comb
  begin
    nxt = r;
    nxt.ext_s1 = EXT_RESET_N;
    nxt.ext_s2 = r.ext_s1;
    nxt.rxd_s1 = RXD;
    nxt.rxd_s2 = r.rxd_s1;
    tx_wr = HOST_TX_VALID && r.tx_ready;
    rx_wr = 1'b0;
    push_valid = 1'b0;
    push_word = '0;
    flush = 1'b0;

    // Operating mode from configuration and software
    if (!CFG_PRESENT)
    begin
      nxt.mode = MODE_UART; // R11
    end
    else if (CFG_MODE == MODE_FIFO || CFG_MODE == MODE_OPTO)
    begin
      nxt.mode = CFG_MODE; // R13
    end
    else
    begin
      nxt.mode = MODE_UART; // R13
    end
    if (SW_SERIAL_ENGINE)
    begin
      nxt.mode = MODE_SERIAL_ENGINE; // R9
    end
    else if (SW_BITBANG)
    begin
      nxt.mode = MODE_BITBANG; // R9
    end
    nxt.serial_en = CFG_PRESENT; // R12
    nxt.pwr_n = SUSPEND; // R16
    uart_on = (r.mode == MODE_UART);

    // Fractional divider of the reference into oversample ticks
    div16 = {BAUD.int_div, BAUD.frac}; // R2
    if (div16 < `DIV16_MIN)
    begin
      div16 = `DIV16_MIN;
    end
    acc_sum = r.acc + 19'(`REF_PER_CLK16); // R1
    tick = (acc_sum >= {1'b0, div16}); // R3 R4
    nxt.acc = tick ? acc_sum - {1'b0, div16} : acc_sum;
    ovs_n = BAUD.x10 ? `OVS_X10 : `OVS_X16; // R1

    // Transmit buffer fill from the host
    if (tx_wr)
    begin
      nxt.tx_wp = r.tx_wp + 1'b1; // R7
    end

    // Transmit shifter and line drive enable
    if (r.tx_st != TX_IDLE && tick)
    begin
      nxt.tx_ovs = bit_end(tick, r.tx_ovs, ovs_n) ? 5'h00
        : r.tx_ovs + 5'h01;
    end
    case (r.tx_st)
      TX_IDLE:
      begin
        if (uart_on && fill(r.tx_wp, r.tx_rp) != '0)
        begin
          nxt.drive_en = 1'b1; // R17
          nxt.tx_ovs = 5'h00;
          nxt.tx_st = TX_LEAD;
        end
      end
      TX_LEAD:
      begin
        if (bit_end(tick, r.tx_ovs, ovs_n))
        begin
          nxt.tx_sh = tx_mem[r.tx_rp[AW-1:0]];
          nxt.tx_rp = r.tx_rp + 1'b1;
          nxt.txd = 1'b0;
          nxt.tx_st = TX_START;
        end
      end
      TX_START:
      begin
        if (bit_end(tick, r.tx_ovs, ovs_n))
        begin
          nxt.txd = r.tx_sh[0];
          nxt.tx_bit = 3'h0;
          nxt.tx_st = TX_DATA;
        end
      end
      TX_DATA:
      begin
        if (bit_end(tick, r.tx_ovs, ovs_n))
        begin
          if (r.tx_bit == `DATA_BITS_LAST)
          begin
            nxt.txd = 1'b1;
            nxt.tx_st = TX_STOP;
          end
          else
          begin
            nxt.tx_sh = {1'b0, r.tx_sh[7:1]};
            nxt.txd = r.tx_sh[1];
            nxt.tx_bit = r.tx_bit + 3'h1;
          end
        end
      end
      TX_STOP:
      begin
        if (bit_end(tick, r.tx_ovs, ovs_n))
        begin
          if (uart_on && fill(r.tx_wp, r.tx_rp) != '0)
          begin
            nxt.tx_sh = tx_mem[r.tx_rp[AW-1:0]]; // R17
            nxt.tx_rp = r.tx_rp + 1'b1;
            nxt.txd = 1'b0;
            nxt.tx_st = TX_START;
          end
          else
          begin
            nxt.drive_en = 1'b0; // R15
            nxt.tx_st = TX_IDLE;
          end
        end
      end
      default:
      begin
        nxt.tx_st = TX_IDLE;
        nxt.drive_en = 1'b0;
      end
    endcase
    nxt.tx_ready = (fill(nxt.tx_wp, nxt.tx_rp) != DEPTH);

    // Receive deserialiser, centre sampling
    if (tick && r.rx_st != RX_IDLE)
    begin
      nxt.rx_ovs = r.rx_ovs + 5'h01;
    end
    case (r.rx_st)
      RX_IDLE:
      begin
        nxt.rx_ovs = 5'h00;
        if (uart_on && !r.rxd_s2)
        begin
          nxt.rx_st = RX_START;
        end
      end
      RX_START:
      begin
        if (bit_end(tick, r.rx_ovs, {1'b0, ovs_n[4:1]}))
        begin
          nxt.rx_ovs = 5'h00;
          nxt.rx_bit = 3'h0;
          nxt.rx_st = r.rxd_s2 ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA:
      begin
        if (bit_end(tick, r.rx_ovs, ovs_n))
        begin
          nxt.rx_ovs = 5'h00;
          nxt.rx_sh = {r.rxd_s2, r.rx_sh[7:1]};
          nxt.rx_bit = r.rx_bit + 3'h1;
          if (r.rx_bit == `DATA_BITS_LAST)
          begin
            nxt.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        if (bit_end(tick, r.rx_ovs, ovs_n))
        begin
          nxt.rx_st = RX_IDLE;
          if (r.rxd_s2 && fill(r.rx_wp, r.rx_rp) != DEPTH)
          begin
            rx_wr = 1'b1; // R8
            nxt.rx_wp = r.rx_wp + 1'b1;
          end
          else if (r.rxd_s2)
          begin
            nxt.overrun = 1'b1;
          end
        end
      end
      default:
      begin
        nxt.rx_st = RX_IDLE;
      end
    endcase

    // Latency timer and microframe clock
    rx_cnt = fill(r.rx_wp, r.rx_rp);
    if (LATENCY_LOAD)
    begin
      nxt.lat_ms = LATENCY_MS; // R5
    end
    nxt.uf_cnt = (r.uf_cnt == 16'(UF_CYCLES - 1)) ? 16'h0000
      : r.uf_cnt + 16'h0001;
    if (r.sending || rx_cnt == '0)
    begin
      nxt.ms_cnt = 16'h0000;
      nxt.lat_cnt = 8'h00;
    end
    else if (r.ms_cnt == 16'(MS_CYCLES - 1))
    begin
      nxt.ms_cnt = 16'h0000;
      nxt.lat_cnt = r.lat_cnt + 8'h01; // R5
    end
    else
    begin
      nxt.ms_cnt = r.ms_cnt + 16'h0001;
    end
    if (r.lat_ms == 8'h00)
    begin
      flush = (r.uf_cnt == 16'(UF_CYCLES - 1)); // R6
    end
    else
    begin
      flush = (r.lat_cnt >= r.lat_ms); // R5
    end

    // Packet start on full packet or timeout with data
    if (!r.sending && rx_cnt != '0
      && (rx_cnt >= `PKT_BYTES || flush))
    begin
      nxt.sending = 1'b1; // R18
      nxt.pkt_left = (rx_cnt >= `PKT_BYTES) ? `PKT_BYTES : rx_cnt;
    end

    // Packet bytes into the two-entry buffer
    if (r.sending)
    begin
      push_valid = 1'b1;
      push_word.data = rx_mem[r.rx_rp[AW-1:0]];
      push_word.last = (r.pkt_left == {{AW{1'b0}}, 1'b1});
      if (push_ready)
      begin
        nxt.rx_rp = r.rx_rp + 1'b1;
        nxt.pkt_left = r.pkt_left - 1'b1;
        if (push_word.last)
        begin
          nxt.sending = 1'b0; // R18
        end
      end
    end

    // External reset pin restarts all but its own synchroniser
    if (!r.ext_s2)
    begin
      nxt = reset_state(); // R10
      nxt.ext_s1 = EXT_RESET_N;
      nxt.ext_s2 = r.ext_s1;
    end
  end

  // State register, power-on reset
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      r <= reset_state(); // R10
    end
    else
    begin
      r <= nxt;
    end
  end

  // Dual-ported byte buffers
  always_ff @(posedge CLK_SYS)
  begin
    if (tx_wr)
    begin
      tx_mem[r.tx_wp[AW-1:0]] <= HOST_TX_DATA; // R7
    end
    if (rx_wr)
    begin
      rx_mem[r.rx_wp[AW-1:0]] <= r.rx_sh; // R8
    end
  end

  // Stall-safe staging toward the host
  pair_buffer u_host_rx
  (
    .clk(CLK_SYS),
    .rst(RESET || !r.ext_s2),
    .in_word(push_word),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_word(HOST_RX),
    .out_valid(HOST_RX_VALID),
    .out_ready(HOST_RX_READY)
  );

  // Flop-driven outputs
  assign TXD = r.txd;
  assign LINE_DRIVE_ENABLE = r.drive_en; // R15
  assign SUSPEND_POWER_ON_N = r.pwr_n; // R16
  assign HOST_TX_READY = r.tx_ready;
  assign CHAN_MODE = r.mode;
  assign SERIAL_NUMBER_EN = r.serial_en;
  assign RX_OVERRUN = r.overrun;
endmodule // uart_channel

// ===== tb/uart_channel_checker.sv
// Purpose: Port assertions for one serial channel
// Assumes: One clock; a live count covers the reset pin delay
// Notes: Bound into uart_channel after the module
`timescale 1ns/10ps
module uart_channel_checker
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic EXT_RESET_N,
  input wire logic TXD,
  input wire logic LINE_DRIVE_ENABLE,
  input wire logic SUSPEND,
  input wire logic SUSPEND_POWER_ON_N,
  input wire logic CFG_PRESENT,
  input wire logic SW_SERIAL_ENGINE,
  input wire logic SW_BITBANG,
  input wire uart_channel_pkg::chan_mode_e CHAN_MODE,
  input wire logic SERIAL_NUMBER_EN,
  input wire uart_channel_pkg::rx_word_s HOST_RX,
  input wire logic HOST_RX_VALID,
  input wire logic HOST_RX_READY
);
  import uart_channel_pkg::*;
  logic [2:0] live_cnt_ff;
  logic [2:0] nxt_live_cnt;
  logic live;
  // Cycles since both resets left, saturating at four
  always_comb
  begin
    nxt_live_cnt = live_cnt_ff;
    if (RESET || !EXT_RESET_N)
      nxt_live_cnt = 3'h0;
    else if (live_cnt_ff != 3'h4)
      nxt_live_cnt = live_cnt_ff + 3'h1;
  end
  always_ff @(posedge CLK_SYS)
    live_cnt_ff <= nxt_live_cnt;
  assign live = (live_cnt_ff == 3'h4);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // A line bit is checked for at least eight cycles, under the shorter oversample ratio
  sequence bit_low; !TXD [*8]; endsequence
  sequence bit_high; TXD [*8]; endsequence
  AST_LEAD: assert property ($fell(TXD) |-> LINE_DRIVE_ENABLE &&
    $past(LINE_DRIVE_ENABLE)) else $error("start without drive lead");
  AST_DROP: assert property ($fell(LINE_DRIVE_ENABLE) |-> TXD &&
    $past(TXD, 8)) else $error("drive dropped inside a bit");
  AST_IDLE: assert property (!LINE_DRIVE_ENABLE |-> TXD)
    else $error("line low while not driven");
  AST_LOW_BIT: assert property ($fell(TXD) |-> bit_low)
    else $error("low bit too short");
  AST_HIGH_BIT: assert property ($rose(TXD) |-> bit_high)
    else $error("high bit too short");
  AST_UART_ONLY: assert property ($rose(LINE_DRIVE_ENABLE) |->
    $past(CHAN_MODE) == MODE_UART) else $error("drive outside serial mode");
  AST_PWR: assert property (live |=>
    SUSPEND_POWER_ON_N == $past(SUSPEND)) else $error("power pin wrong");
  AST_SN: assert property (live |=>
    SERIAL_NUMBER_EN == $past(CFG_PRESENT)) else $error("serial flag");
  AST_ENGINE: assert property (live && SW_SERIAL_ENGINE |=>
    CHAN_MODE == MODE_SERIAL_ENGINE) else $error("engine mode lost");
  AST_DEFAULT: assert property (live && !CFG_PRESENT && !SW_BITBANG
    && !SW_SERIAL_ENGINE |=> CHAN_MODE == MODE_UART)
    else $error("default mode wrong");
  AST_RX_HOLD: assert property (live && HOST_RX_VALID && !HOST_RX_READY
    |=> HOST_RX_VALID && $stable(HOST_RX)) else $error("word not held");
endmodule // uart_channel_checker

bind uart_channel uart_channel_checker i_chk (.CLK_SYS, .RESET,
  .EXT_RESET_N, .TXD, .LINE_DRIVE_ENABLE, .SUSPEND, .SUSPEND_POWER_ON_N,
  .CFG_PRESENT, .SW_SERIAL_ENGINE, .SW_BITBANG, .CHAN_MODE,
  .SERIAL_NUMBER_EN, .HOST_RX, .HOST_RX_VALID, .HOST_RX_READY);

// ===== tb/line_model.sv
// Purpose: Line transceiver beside the channel pins
// Assumes: Fixed bit period in system cycles, 8N1 frames
// Notes: Line idles high as through a pull-up
`timescale 1ns/10ps
module line_model
#(
  parameter int BIT_CYC = 10
)
(
  input wire logic clk,
  input wire logic txd,
  input wire logic drive_en,
  output logic rxd
);
  logic [7:0] got[$];
  initial rxd = 1'h1;
  // Decode driven frames, sampling mid bit
  always
  begin : decode
    logic [7:0] b;
    @(negedge txd iff drive_en);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk);
      b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    got.push_back(b);
  end
  // Send one frame; stop low gives a framing fault
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'h0};
    @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rxd <= 1'h1;
  endtask
endmodule // line_model

// ===== tb/uart_channel_tb.sv
// Purpose: Self-checking bench for one serial channel
// Assumes: One tick per cycle, ten ticks a bit
// Notes: Short ms and microframe counts
`timescale 1ns/10ps
module uart_channel_tb;
  import uart_channel_pkg::*;
  typedef struct {logic p; chan_mode_e c; logic se, bb, s;
    chan_mode_e m;} row_s;
  logic CLK_SYS, RESET, EXT_RESET_N, RXD, TXD, LINE_DRIVE_ENABLE, SUSPEND;
  logic SUSPEND_POWER_ON_N, LATENCY_LOAD, CFG_PRESENT, SW_SERIAL_ENGINE;
  logic SW_BITBANG, SERIAL_NUMBER_EN, HOST_TX_VALID, HOST_TX_READY;
  logic HOST_RX_VALID, HOST_RX_READY, RX_OVERRUN;
  logic [7:0] LATENCY_MS, HOST_TX_DATA;
  baud_cfg_s BAUD;
  chan_mode_e CFG_MODE, CHAN_MODE;
  rx_word_s HOST_RX;
  int fails, checked, cycles, en_cnt;
  row_s rows[7] = '{'{1'h0, MODE_FIFO, 1'h0, 1'h0, 1'h1, MODE_UART},
    '{1'h1, MODE_BITBANG, 1'h0, 1'h0, 1'h1, MODE_UART},
    '{1'h1, MODE_FIFO, 1'h0, 1'h0, 1'h0, MODE_FIFO},
    '{1'h1, MODE_OPTO, 1'h0, 1'h0, 1'h1, MODE_OPTO},
    '{1'h1, MODE_UART, 1'h0, 1'h0, 1'h0, MODE_UART},
    '{1'h0, MODE_UART, 1'h1, 1'h1, 1'h0, MODE_SERIAL_ENGINE},
    '{1'h0, MODE_UART, 1'h0, 1'h1, 1'h0, MODE_BITBANG}};
  uart_channel #(.MS_CYCLES(20), .UF_CYCLES(16)) i_dut (.CLK_SYS, .RESET,
    .EXT_RESET_N, .RXD, .TXD, .LINE_DRIVE_ENABLE, .SUSPEND,
    .SUSPEND_POWER_ON_N, .BAUD, .LATENCY_MS, .LATENCY_LOAD, .CFG_PRESENT,
    .CFG_MODE, .SW_SERIAL_ENGINE, .SW_BITBANG, .CHAN_MODE,
    .SERIAL_NUMBER_EN, .HOST_TX_DATA, .HOST_TX_VALID, .HOST_TX_READY,
    .HOST_RX, .HOST_RX_VALID, .HOST_RX_READY, .RX_OVERRUN);
  line_model #(.BIT_CYC(10)) i_line (.clk(CLK_SYS), .txd(TXD),
    .drive_en(LINE_DRIVE_ENABLE), .rxd(RXD));
  task automatic check(input string what, input logic [31:0] got,
    input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #2;
  endtask
  // Offer one byte and hold it until taken
  task automatic push(input logic [7:0] b);
    HOST_TX_DATA = b;
    HOST_TX_VALID = 1'h1;
    while (HOST_TX_READY !== 1'h1) tick(1);
    tick(1);
  endtask
  // Wait for a packet, then pop it with stalls between words
  task automatic get_pkt(input int lo, hi, input logic [7:0] d, input int n);
    int t;
    t = 0;
    tick(0);
    while (HOST_RX_VALID !== 1'h1 && t < 1000)
    begin
      tick(1);
      t++;
    end
    check("flush delay", t >= lo && t <= hi, 1'h1);
    for (int i = 0; i < n; i++)
    begin
      tick(2);
      check("rx valid", HOST_RX_VALID, 1'h1);
      check("rx data", HOST_RX.data, d + i);
      check("rx last", HOST_RX.last, i == n - 1);
      HOST_RX_READY = 1'h1;
      tick(1);
      HOST_RX_READY = 1'h0;
    end
    check("rx drained", HOST_RX_VALID, 1'h0);
  endtask
  initial
  begin
    CLK_SYS = 1'h0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  // Cycle ceiling and drive-enable cycle count
  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (LINE_DRIVE_ENABLE === 1'h1)
      en_cnt++;
    if (cycles == 20000)
    begin
      fails++;
      close_out();
    end
  end
  initial
  begin
    {RESET, EXT_RESET_N, SUSPEND, LATENCY_LOAD, HOST_TX_VALID} = 5'h1c;
    {CFG_PRESENT, SW_SERIAL_ENGINE, SW_BITBANG, HOST_RX_READY} = 4'h0;
    {LATENCY_MS, HOST_TX_DATA} = 16'h0;
    CFG_MODE = MODE_UART;
    BAUD = '{int_div: 14'h0003, frac: 4'h0, x10: 1'h1};
    tick(2);
    check("reset txd", TXD, 1'h1);
    check("reset drive", LINE_DRIVE_ENABLE, 1'h0);
    check("reset power", SUSPEND_POWER_ON_N, 1'h1);
    check("reset tx ready", HOST_TX_READY, 1'h0);
    check("reset rx valid", HOST_RX_VALID, 1'h0);
    check("reset overrun", RX_OVERRUN, 1'h0);
    RESET = 1'h0;
    SUSPEND = 1'h0;
    tick(2);
    check("ready held", HOST_TX_READY, 1'h0);
    tick(2);
    foreach (rows[i])
    begin
      CFG_PRESENT = rows[i].p;
      CFG_MODE = rows[i].c;
      SW_SERIAL_ENGINE = rows[i].se;
      SW_BITBANG = rows[i].bb;
      SUSPEND = rows[i].s;
      tick(2);
      check("mode", CHAN_MODE, rows[i].m);
      check("serial number", SERIAL_NUMBER_EN, rows[i].p);
      check("power", SUSPEND_POWER_ON_N, rows[i].s);
    end
    en_cnt = 0;
    push(8'ha5);
    HOST_TX_VALID = 1'h0;
    tick(200);
    check("drive in bit-bang", en_cnt, 0);
    SW_BITBANG = 1'h0;
    push(8'h3c);
    push(8'h01);
    HOST_TX_VALID = 1'h0;
    tick(450);
    check("frames", i_line.got.size(), 3);
    foreach (i_line.got[i])
      check("line byte", i_line.got[i], i ? (i == 1 ? 8'h3c : 8'h01) :
        8'ha5);
    check("drive span", en_cnt >= 305 && en_cnt <= 315, 1'h1);
    i_line.send(8'h5a, 1'h1);
    i_line.send(8'h5b, 1'h1);
    // 16 ms of 20 cycles from the first byte, 103 cycles already gone
    get_pkt(210, 230, 8'h5a, 2);
    LATENCY_LOAD = 1'h1;
    tick(1);
    LATENCY_LOAD = 1'h0;
    i_line.send(8'h80, 1'h0);
    i_line.send(8'h81, 1'h1);
    get_pkt(0, 40, 8'h81, 1);
    check("overrun", RX_OVERRUN, 1'h0);
    SW_SERIAL_ENGINE = 1'h1;
    tick(2);
    EXT_RESET_N = 1'h0;
    tick(4);
    check("pin reset mode", CHAN_MODE, MODE_UART);
    check("pin reset ready", HOST_TX_READY, 1'h0);
    EXT_RESET_N = 1'h1;
    SW_SERIAL_ENGINE = 1'h0;
    tick(4);
    check("pin release ready", HOST_TX_READY, 1'h1);
    // Fractional divider with x16: 176 ticks at six per seven cycles
    BAUD = '{int_div: 14'h0003, frac: 4'h8, x10: 1'h0};
    en_cnt = 0;
    push(8'hff);
    HOST_TX_VALID = 1'h0;
    tick(260);
    check("drive x16 frac", en_cnt >= 203 && en_cnt <= 208, 1'h1);
    close_out();
  end
endmodule // uart_channel_tb
